// ### core/cdsz_consts.svh
`ifndef CDSZ_CONSTS_SVH
`define CDSZ_CONSTS_SVH

`define CDSZ_INSTR_W 14
`define CDSZ_DATA_W 8
`define CDSZ_ADDR_W 7
`define CDSZ_OPC_HI 13
`define CDSZ_OPC_LO 8
`define CDSZ_DEST_BIT 7
`define CDSZ_ADDR_HI 6
`define CDSZ_ADDR_LO 0
`define CDSZ_OPC_COMPLEMENT 6'h09
`define CDSZ_OPC_DEC_SKIP 6'h0b
`define CDSZ_DEST_ACCUM 1'h0
`define CDSZ_RST_ACCUM 8'h00
`define CDSZ_RST_ZERO 1'h0
`define CDSZ_RST_DATA 8'h00
`define CDSZ_RST_ADDR 7'h00
`define CDSZ_PHASES_PER_CYCLE 4

`endif

// ### core/cdsz_pkg.sv
package cdsz_pkg;
    typedef enum logic [1:0] {
        quarter_phase_one,
        quarter_phase_two,
        quarter_phase_three,
        quarter_phase_four
    } quarter_phase_t;

    typedef enum logic [1:0] {
        op_none,
        complement_file_op,
        decrement_skip_zero_op
    } exec_op_t;

    typedef struct packed {
        logic [13:0] word;
        logic valid;
    } fetch_in_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [6:0] addr;
        logic [7:0] wr_data;
    } file_port_t;

    typedef struct packed {
        quarter_phase_t phase;
        exec_op_t op;
        logic dest;
        logic [6:0] addr;
        logic [7:0] operand;
        logic [7:0] result;
        logic skip_now;
        logic [7:0] accum;
        logic zero;
    } exec_state_t;
endpackage

// ### core/complement_decrement_exec.sv
`timescale 1ns/10ps
`include "cdsz_consts.svh"

module complement_decrement_exec (
    input wire logic mclk,
    input wire logic reset,
    input cdsz_pkg::fetch_in_t fetch,
    output logic instr_take,
    input wire logic [7:0] file_rd_data,
    output cdsz_pkg::file_port_t file_port,
    output cdsz_pkg::quarter_phase_t quarter_phase,
    output logic skip_active,
    output logic [7:0] accum_value,
    output logic zero_flag
);
    import cdsz_pkg::*;

    exec_state_t s_q;
    exec_state_t s_d;
    logic [5:0] opc;
    logic active;

    function automatic logic [7:0] alu(input exec_op_t op, input logic [7:0] a);
        if (op == complement_file_op) begin
            return ~a;
        end
        return a - 8'h01;
    endfunction

    assign opc = fetch.word[`CDSZ_OPC_HI:`CDSZ_OPC_LO];
    assign active = (s_q.op != op_none) && !s_q.skip_now;

    // the fetched word is only consumed at decode; a skipped word is still taken but discarded
    assign instr_take = (s_q.phase == quarter_phase_one) && fetch.valid;

    always_comb begin
        s_d = s_q;
        case (s_q.phase)
            quarter_phase_one: begin
                s_d.phase = quarter_phase_two;
                s_d.op = op_none;
                if (fetch.valid && !s_q.skip_now) begin
                    s_d.dest = fetch.word[`CDSZ_DEST_BIT];
                    s_d.addr = fetch.word[`CDSZ_ADDR_HI:`CDSZ_ADDR_LO];
                    if (opc == `CDSZ_OPC_COMPLEMENT) begin
                        s_d.op = complement_file_op;
                    end else if (opc == `CDSZ_OPC_DEC_SKIP) begin
                        s_d.op = decrement_skip_zero_op;
                    end
                end
            end
            quarter_phase_two: begin
                s_d.phase = quarter_phase_three;
                if (active) begin
                    s_d.operand = file_rd_data;
                end
            end
            quarter_phase_three: begin
                s_d.phase = quarter_phase_four;
                if (active) begin
                    s_d.result = alu(s_q.op, s_q.operand);
                end
            end
            quarter_phase_four: begin
                s_d.phase = quarter_phase_one;
                s_d.skip_now = 1'b0;
                if (active) begin
                    if (s_q.dest == `CDSZ_DEST_ACCUM) begin
                        s_d.accum = s_q.result;
                    end
                    if (s_q.op == complement_file_op) begin
                        s_d.zero = (s_q.result == 8'h00);
                    end else begin
                        // decrement-skip never touches the flag
                        s_d.skip_now = (s_q.result == 8'h00);
                    end
                end
            end
            default: begin
                s_d.phase = quarter_phase_one;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q.phase <= quarter_phase_one;
            s_q.op <= op_none;
            s_q.dest <= 1'b0;
            s_q.addr <= `CDSZ_RST_ADDR;
            s_q.operand <= `CDSZ_RST_DATA;
            s_q.result <= `CDSZ_RST_DATA;
            s_q.skip_now <= 1'b0;
            s_q.accum <= `CDSZ_RST_ACCUM;
            s_q.zero <= `CDSZ_RST_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    // read in phase two, write in phase four; the file answers combinationally
    assign file_port.rd_en = active && (s_q.phase == quarter_phase_two);
    assign file_port.wr_en = active && (s_q.phase == quarter_phase_four) && s_q.dest;
    assign file_port.addr = s_q.addr;
    assign file_port.wr_data = s_q.result;
    assign quarter_phase = s_q.phase;
    assign skip_active = s_q.skip_now;
    assign accum_value = s_q.accum;
    assign zero_flag = s_q.zero;

    property p_complement_file_op_invert;
        @(posedge mclk) disable iff (reset)
        (s_q.phase == quarter_phase_two && active && s_q.op == complement_file_op)
            |=> ##1 (s_q.result == ~$past(file_rd_data, 2));
    endproperty
    a_complement_file_op_invert: assert property (p_complement_file_op_invert) else $error("complement result not inverted");

    property p_complement_file_op_dest;
        @(posedge mclk) disable iff (reset)
        (s_q.phase == quarter_phase_four && active && s_q.op == complement_file_op)
            |-> (file_port.wr_en == s_q.dest) ##1 (s_q.dest || accum_value == $past(s_q.result));
    endproperty
    a_complement_file_op_dest: assert property (p_complement_file_op_dest) else $error("complement went to wrong destination");

    property p_complement_file_op_one_cycle;
        @(posedge mclk) disable iff (reset)
        (instr_take && !skip_active && opc == `CDSZ_OPC_COMPLEMENT)
            |=> file_port.rd_en ##2 (quarter_phase == quarter_phase_four) ##1 (!skip_active && instr_take == fetch.valid);
    endproperty
    a_complement_file_op_one_cycle: assert property (p_complement_file_op_one_cycle) else $error("complement did not fit one cycle");

    property p_dec_result;
        @(posedge mclk) disable iff (reset)
        (s_q.phase == quarter_phase_two && active && s_q.op == decrement_skip_zero_op)
            |-> ##2 (s_q.result == $past(file_rd_data, 2) - 8'h01);
    endproperty
    a_dec_result: assert property (p_dec_result) else $error("decrement result wrong");

    property p_dec_dest;
        @(posedge mclk) disable iff (reset)
        (s_q.phase == quarter_phase_four && active && s_q.op == decrement_skip_zero_op)
            |-> (file_port.wr_en == s_q.dest) ##1 (s_q.dest || accum_value == $past(s_q.result));
    endproperty
    a_dec_dest: assert property (p_dec_dest) else $error("decrement went to wrong destination");

    property p_no_skip;
        @(posedge mclk) disable iff (reset)
        (s_q.phase == quarter_phase_four && active && s_q.op == decrement_skip_zero_op && s_q.result != 8'h00)
            |=> !skip_active;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("skipped on nonzero result");

    property p_skip_zero;
        @(posedge mclk) disable iff (reset)
        (s_q.phase == quarter_phase_four && active && s_q.op == decrement_skip_zero_op && s_q.result == 8'h00)
            |=> skip_active [*4] ##1 !skip_active;
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("zero result did not skip one cycle");

    // the decrement's own write lands on the edge that opens the skip, so stability is judged one edge on
    property p_skip_quiet;
        @(posedge mclk) disable iff (reset)
        skip_active |-> (!file_port.rd_en && !file_port.wr_en)
            ##1 ($stable(accum_value) && $stable(zero_flag));
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("activity during skipped cycle");

    property p_flags;
        @(posedge mclk) disable iff (reset)
        (s_q.phase == quarter_phase_four && active)
            |=> (s_q.op == decrement_skip_zero_op) ? $stable(zero_flag) : (zero_flag == ($past(s_q.result) == 8'h00));
    endproperty
    a_flags: assert property (p_flags) else $error("zero flag handled wrongly");

    property p_phase_order;
        @(posedge mclk) disable iff (reset)
        (quarter_phase == quarter_phase_one)
            |=> (quarter_phase == quarter_phase_two) ##1 (quarter_phase == quarter_phase_three)
            ##1 (quarter_phase == quarter_phase_four) ##1 (quarter_phase == quarter_phase_one);
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("quarter phases out of order");

    property p_take_addr;
        @(posedge mclk) disable iff (reset)
        (instr_take && !skip_active)
            |=> (file_port.addr == $past(fetch.word[`CDSZ_ADDR_HI:`CDSZ_ADDR_LO]));
    endproperty
    a_take_addr: assert property (p_take_addr) else $error("file address not taken from word");

    property p_dec_decode;
        @(posedge mclk) disable iff (reset)
        (instr_take && !skip_active && opc == `CDSZ_OPC_DEC_SKIP)
            |=> file_port.rd_en ##2 (file_port.wr_en == $past(fetch.word[`CDSZ_DEST_BIT], 3));
    endproperty
    a_dec_decode: assert property (p_dec_decode) else $error("decrement phases wrong");

    property p_skip_discard;
        @(posedge mclk) disable iff (reset)
        (skip_active && instr_take)
            |=> !file_port.rd_en ##2 !file_port.wr_en;
    endproperty
    a_skip_discard: assert property (p_skip_discard) else $error("skipped word was executed");

    property p_complement_file_op_no_skip;
        @(posedge mclk) disable iff (reset)
        (s_q.phase == quarter_phase_four && active && s_q.op == complement_file_op)
            |=> !skip_active;
    endproperty
    a_complement_file_op_no_skip: assert property (p_complement_file_op_no_skip) else $error("complement took a second cycle");

    property p_accum_hold;
        @(posedge mclk) disable iff (reset)
        (quarter_phase != quarter_phase_four)
            |=> $stable(accum_value);
    endproperty
    a_accum_hold: assert property (p_accum_hold) else $error("accumulator changed outside phase four");

    property p_zero_hold;
        @(posedge mclk) disable iff (reset)
        (quarter_phase != quarter_phase_four)
            |=> $stable(zero_flag);
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("zero flag changed outside phase four");

    property p_other_op;
        @(posedge mclk) disable iff (reset)
        (instr_take && !skip_active && opc != `CDSZ_OPC_COMPLEMENT && opc != `CDSZ_OPC_DEC_SKIP)
            |=> !file_port.rd_en ##2 !file_port.wr_en ##1 $stable(accum_value);
    endproperty
    a_other_op: assert property (p_other_op) else $error("unknown opcode did something");
endmodule

// ### verification/complement_and_decrement_skip_exec_tb.sv
`timescale 1ns/10ps
module complement_and_decrement_skip_exec_tb;
    import cdsz_pkg::*;
    typedef struct packed {
        logic [7:0] acc;
        logic z;
        logic sk;
        logic [6:0] a;
        logic [7:0] f;
    } note_t;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    fetch_in_t fetch = '0;
    logic [7:0] file_rd_data;
    file_port_t file_port;
    quarter_phase_t quarter_phase;
    logic instr_take;
    logic skip_active;
    logic zero_flag;
    logic [7:0] accum_value;
    logic [7:0] mem [128];
    logic [7:0] ref_mem [128];
    logic [5:0] opcs [4] = '{6'h09, 6'h0b, 6'h0b, 6'h03};
    note_t notes [$];
    note_t n;
    logic [7:0] e_acc = 8'h00;
    logic e_z = 1'b0;
    logic e_sk = 1'b0;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    integer seed = 32'h32f4;

    complement_decrement_exec u_dut (.mclk(mclk), .reset(reset), .fetch(fetch), .instr_take(instr_take),
        .file_rd_data(file_rd_data), .file_port(file_port), .quarter_phase(quarter_phase),
        .skip_active(skip_active), .accum_value(accum_value), .zero_flag(zero_flag));

    always #25 mclk = ~mclk;
    // unread cycles show the inverse so a late or early sample is caught
    assign file_rd_data = file_port.rd_en ? mem[file_port.addr] : ~mem[file_port.addr];
    always @(posedge mclk) begin
        if (file_port.wr_en === 1'b1) mem[file_port.addr] <= file_port.wr_data;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic issue(input logic [5:0] opc, input logic d, input logic [6:0] a);
        logic [7:0] r;
        @(negedge mclk);
        while (quarter_phase !== quarter_phase_four) @(negedge mclk);
        @(posedge mclk);
        fetch <= '{word: {opc, d, a}, valid: 1'b1};
        r = (opc == 6'h09) ? ~ref_mem[a] : ref_mem[a] - 8'h01;
        if (e_sk || (opc != 6'h09 && opc != 6'h0b)) e_sk = 1'b0;
        else begin
            if (d) ref_mem[a] = r;
            else e_acc = r;
            if (opc == 6'h09) e_z = (r == 8'h00);
            e_sk = (opc == 6'h0b) && (r == 8'h00);
        end
        notes.push_back('{acc: e_acc, z: e_z, sk: e_sk, a: a, f: ref_mem[a]});
    endtask

    // a result is due in the phase one after its instruction, when the next note is queued
    always @(negedge mclk) begin
        if (quarter_phase === quarter_phase_one && notes.size() > 1) begin
            n = notes.pop_front();
            chk("accum", n.acc, accum_value);
            chk("zero", 8'(n.z), 8'(zero_flag));
            chk("skip", 8'(n.sk), 8'(skip_active));
            chk("file", n.f, mem[n.a]);
        end
        chk("take", 8'((quarter_phase === quarter_phase_one) && fetch.valid), 8'(instr_take));
        if (file_port.rd_en === 1'b1 || file_port.wr_en === 1'b1) begin
            chk("strobe phase", 8'(file_port.rd_en ? quarter_phase_two : quarter_phase_four), 8'(quarter_phase));
            chk("strobe in skip", 8'h00, 8'(skip_active));
        end
    end

    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'((i < 8) ? ($random(seed) & 3) : $random(seed));
            ref_mem[i] = mem[i];
        end
        mem[16] = 8'hff;
        mem[17] = 8'h01;
        mem[18] = 8'h02;
        for (int i = 16; i < 19; i++) ref_mem[i] = mem[i];
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        issue(6'h09, 1'b0, 7'h10);
        issue(6'h0b, 1'b1, 7'h12);
        issue(6'h0b, 1'b1, 7'h12);
        issue(6'h09, 1'b1, 7'h11);
        issue(6'h0b, 1'b0, 7'h11);
        issue(6'h0b, 1'b1, 7'h12);
        issue(6'h09, 1'b1, 7'h13);
        for (int k = 0; k < 60; k++) begin
            issue(opcs[$unsigned($random(seed)) % 4], 1'($random(seed)), 7'($random(seed) & 7));
        end
        issue(6'h00, 1'b0, 7'h00);
        issue(6'h00, 1'b0, 7'h00);
        repeat (2) @(posedge mclk);
        summarize();
    end
endmodule
